// >>> rtl/mcp_top.sv
// Control-pin logic of the hardware monitor: interrupt, reset, test and VID pins
//
// Notes on behaviour
// (R1) The open-drain interrupt pin is only driven while config bit 1 at 40h is set, and is off after reset.
// (R2) Setting config bit 4 at 40h pulls the master reset pin low for at least 45 ms.
// (R3) A low level on the master reset pin made by someone else is reported as a reset request.
// (R4) A high test-select input enters connectivity test mode and turns the address pin into the result output.
// (R5) Outside test mode the shared test pin serves as the analog output.
// (R6) The four lower voltage-ID pins are sampled into one readable status register.
// (R7) The fifth voltage-ID pin is captured into a status register of its own.
// (R8) Each voltage-ID pin can be switched by software to act as an interrupt input.
// (R9) Pin inputs pass a two-flop synchroniser before any logic reads them.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module mcp_top #(
  parameter int unsigned RST_PULSE_CYC = int'(mcp_pkg::RST_PULSE_CYC)
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Interrupt
  output logic             o_irq,
  output logic             o_int_pin_o,
  output logic             o_int_pin_oe,
  // Master reset pin
  input  wire logic        i_master_rst_pin,
  output logic             o_master_rst_pin_o,
  output logic             o_master_rst_pin_oe,
  output logic             o_reset_req,
  // Test pins
  input  wire logic        i_test_select_or_analog_out,
  output logic             o_analog_out_en,
  output logic             o_test_mode,
  output logic             o_test_result_or_addr_select_o,
  output logic             o_test_result_or_addr_select_oe,
  // Voltage-ID pins
  input  wire logic        i_core_volt_id_0,
  input  wire logic        i_core_volt_id_1,
  input  wire logic        i_core_volt_id_2,
  input  wire logic        i_core_volt_id_3,
  input  wire logic        i_core_volt_id_4
);

  localparam int VW = mcp_pkg::VID_W;
  localparam int SW = mcp_pkg::STS_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [VW-1:0] vid_pins;
  logic [VW-1:0] vid_sync;
  logic          rst_pin_sync;
  logic          test_sync;

  assign vid_pins = {i_core_volt_id_4, i_core_volt_id_3, i_core_volt_id_2,
                     i_core_volt_id_1, i_core_volt_id_0};

  mcp_sync #(.W(VW), .INIT({VW{1'b1}})) u_vid_sync (         // [R9]
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (vid_pins),
    .o_q     (vid_sync)
  );

  mcp_sync #(.W(2), .INIT(2'b10)) u_ctl_sync (               // [R9]
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_master_rst_pin, i_test_select_or_analog_out}),
    .o_q     ({rst_pin_sync, test_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  mcp_pkg::mcp_apb_req_t req;
  logic                  acc;
  logic                  wr_fire;
  logic                  hit_cfg;
  logic                  hit_vlo;
  logic                  hit_vhi;
  logic                  hit_mode;
  logic                  hit_sts;
  logic                  hit_clr;
  logic                  hit_en;
  logic                  mapped;
  logic [31:0]           rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  assign req      = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                      paddr: i_paddr, pwdata: i_pwdata};
  assign acc      = req.psel && req.penable;
  assign wr_fire  = acc && o_pready && req.pwrite && mapped;
  assign hit_cfg  = hit(req.paddr, mcp_pkg::CFG_OFS);
  assign hit_vlo  = hit(req.paddr, mcp_pkg::VID_LO_OFS);
  assign hit_vhi  = hit(req.paddr, mcp_pkg::VID_HI_OFS);
  assign hit_mode = hit(req.paddr, mcp_pkg::VID_MODE_OFS);
  assign hit_sts  = hit(req.paddr, mcp_pkg::IRQ_STS_OFS);
  assign hit_clr  = hit(req.paddr, mcp_pkg::IRQ_CLR_OFS);
  assign hit_en   = hit(req.paddr, mcp_pkg::IRQ_EN_OFS);
  assign mapped   = hit_cfg | hit_vlo | hit_vhi | hit_mode | hit_sts | hit_clr | hit_en;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]    cfg_reg;
  logic [7:0]    cfg_next;
  logic [3:0]    vid_lo_reg;
  logic          vid_hi_reg;
  logic [VW-1:0] vid_mode_reg;
  logic [VW-1:0] vid_prev_reg;
  logic [SW-1:0] sts_reg;
  logic [SW-1:0] sts_next;
  logic [SW-1:0] sts_set;
  logic [SW-1:0] sts_clr;
  logic [SW-1:0] en_reg;
  logic          pulse_cmd;
  logic          pulse_done;
  logic          ext_rst_seen;
  logic          ext_rst_prev_reg;
  // Reset-pulse state, read by the config self-clear below
  mcp_pkg::mcp_rst_state_t rst_state;
  mcp_pkg::mcp_rst_state_t rst_state_next;
  logic [1:0]              guard_reg;

  // Bit 4 is a self-clearing command: it reads back high while the pulse runs
  assign pulse_cmd = wr_fire && hit_cfg && req.pwdata[mcp_pkg::CFG_RST_PULSE_BIT];   // [R2]
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_fire && hit_cfg) begin
      cfg_next = req.pwdata[7:0];
    end
    cfg_next[mcp_pkg::CFG_RST_PULSE_BIT] = pulse_cmd || rst_state != mcp_pkg::RST_IDLE;
  end

  // Interrupt-mode pins raise an event on a falling level (the pins idle high)
  assign sts_set = {pulse_done, ext_rst_seen && !ext_rst_prev_reg,
                    vid_mode_reg & vid_prev_reg & ~vid_sync};                          // [R8]
  assign sts_clr  = (wr_fire && hit_clr) ? req.pwdata[SW-1:0] : '0;
  assign sts_next = (sts_reg & ~sts_clr) | sts_set;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg          <= mcp_pkg::CFG_RST;
      vid_lo_reg       <= 4'hf;
      vid_hi_reg       <= 1'b1;
      vid_mode_reg     <= mcp_pkg::VID_MODE_RST;
      vid_prev_reg     <= {VW{1'b1}};
      sts_reg          <= '0;
      en_reg           <= mcp_pkg::IRQ_EN_RST;
      ext_rst_prev_reg <= 1'b0;
    end else begin
      cfg_reg          <= cfg_next;                                                    // [R1]
      vid_lo_reg       <= vid_sync[3:0];                                               // [R6]
      vid_hi_reg       <= vid_sync[4];                                                 // [R7]
      vid_prev_reg     <= vid_sync;
      sts_reg          <= sts_next;
      ext_rst_prev_reg <= ext_rst_seen;
      if (wr_fire && hit_mode) begin
        vid_mode_reg <= req.pwdata[VW-1:0];                                            // [R8]
      end
      if (wr_fire && hit_en) begin
        en_reg <= req.pwdata[SW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and APB answer: one wait state, so pready is a flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux[7:0] = cfg_reg;
    end
    if (hit_vlo) begin
      rd_mux[3:0] = vid_lo_reg;                                                        // [R6]
    end
    if (hit_vhi) begin
      rd_mux[0] = vid_hi_reg;                                                          // [R7]
    end
    if (hit_mode) begin
      rd_mux[VW-1:0] = vid_mode_reg;
    end
    if (hit_sts) begin
      rd_mux[SW-1:0] = sts_reg;
    end
    if (hit_en) begin
      rd_mux[SW-1:0] = en_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc && !o_pready;
      o_pslverr <= acc && !o_pready && !mapped;
      if (acc && !o_pready && !req.pwrite) begin
        o_prdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master reset pin: drive, then mask our own echo for a few cycles

  mcp_pulse_timer #(.CYC(RST_PULSE_CYC)) u_pulse (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (pulse_cmd && rst_state == mcp_pkg::RST_IDLE),
    .o_done  (pulse_done)
  );

  always_comb begin
    rst_state_next = rst_state;
    unique case (rst_state)
      mcp_pkg::RST_IDLE:  if (pulse_cmd) rst_state_next = mcp_pkg::RST_DRIVE;           // [R2]
      mcp_pkg::RST_DRIVE: if (pulse_done) rst_state_next = mcp_pkg::RST_GUARD;
      mcp_pkg::RST_GUARD: if (guard_reg == 2'(mcp_pkg::RST_GUARD_CYC - 1)) rst_state_next = mcp_pkg::RST_IDLE;
      default:            rst_state_next = mcp_pkg::RST_IDLE;
    endcase
  end

  assign ext_rst_seen = !rst_pin_sync && rst_state == mcp_pkg::RST_IDLE;               // [R3]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_state           <= mcp_pkg::RST_IDLE;
      guard_reg           <= 2'h0;
      o_master_rst_pin_oe <= 1'b0;
      o_reset_req         <= 1'b0;
    end else begin
      rst_state           <= rst_state_next;
      guard_reg           <= (rst_state == mcp_pkg::RST_GUARD) ? guard_reg + 2'h1 : 2'h0;
      o_master_rst_pin_oe <= rst_state_next == mcp_pkg::RST_DRIVE;                     // [R2]
      o_reset_req         <= ext_rst_seen;                                             // [R3]
    end
  end
  assign o_master_rst_pin_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs and test mode
  logic irq_any;

  assign irq_any = |(sts_reg & en_reg);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq                           <= 1'b0;
      o_int_pin_oe                    <= 1'b0;
      o_test_mode                     <= 1'b0;
      o_analog_out_en                 <= 1'b1;
      o_test_result_or_addr_select_o  <= 1'b0;
      o_test_result_or_addr_select_oe <= 1'b0;
    end else begin
      o_irq                           <= irq_any;
      o_int_pin_oe                    <= irq_any && cfg_reg[mcp_pkg::CFG_INT_EN_BIT];  // [R1]
      o_test_mode                     <= test_sync;                                    // [R4]
      o_analog_out_en                 <= !test_sync;                                   // [R5]
      o_test_result_or_addr_select_o  <= ~&{vid_sync, rst_pin_sync};                   // [R4]
      o_test_result_or_addr_select_oe <= test_sync;                                    // [R4]
    end
  end
  assign o_int_pin_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [31:0] drive_len_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_len_reg <= 32'h0;
    end else begin
      drive_len_reg <= o_master_rst_pin_oe ? drive_len_reg + 32'h1 : 32'h0;
    end
  end

  sequence cfg_pulse_write_s;
    wr_fire && hit_cfg && req.pwdata[mcp_pkg::CFG_RST_PULSE_BIT] && rst_state == mcp_pkg::RST_IDLE;
  endsequence

  sequence pin_low_s;
    o_master_rst_pin_oe [*2];
  endsequence

  int_gate_a: assert property (o_int_pin_oe |-> $past(cfg_reg[mcp_pkg::CFG_INT_EN_BIT])) // [R1]
    else $error("interrupt pin driven while disabled");
  rst_start_a: assert property (cfg_pulse_write_s |=> pin_low_s)                           // [R2]
    else $error("reset pulse did not start after config write");
  rst_width_a: assert property ($fell(o_master_rst_pin_oe) |-> $past(drive_len_reg) >= RST_PULSE_CYC - 1) // [R2]
    else $error("reset pulse shorter than minimum");
  ext_req_a: assert property (!rst_pin_sync && rst_state == mcp_pkg::RST_IDLE |=> o_reset_req) // [R3]
    else $error("external reset not reported");
  test_mode_a: assert property (test_sync |=> o_test_mode && o_test_result_or_addr_select_oe) // [R4]
    else $error("test mode not entered");
  aout_sel_a: assert property (o_analog_out_en != o_test_mode)                             // [R5]
    else $error("analog output and test mode overlap");
  vid_low_a: assert property (##1 vid_lo_reg == $past(vid_sync[3:0]))                     // [R6]
    else $error("lower voltage-ID status stale");
  vid_high_a: assert property (##1 vid_hi_reg == $past(vid_sync[4]))                       // [R7]
    else $error("fifth voltage-ID status stale");
  vid_irq_a: assert property (vid_mode_reg[0] && vid_prev_reg[0] && !vid_sync[0] |=> sts_reg[0]) // [R8]
    else $error("voltage-ID interrupt event lost");

  sequence ext_low_s;
    ext_rst_seen && !ext_rst_prev_reg;
  endsequence

  // Pin driving and reset-pin echo
  int_drive_a: assert property (irq_any && cfg_reg[mcp_pkg::CFG_INT_EN_BIT] |=> o_int_pin_oe) // [R1]
    else $error("enabled interrupt not driven on pin");
  int_clear_a: assert property (!cfg_reg[mcp_pkg::CFG_INT_EN_BIT] |=> !o_int_pin_oe) // [R1]
    else $error("interrupt pin still driven after disable");
  own_echo_a: assert property (o_master_rst_pin_oe |=> !o_reset_req) // [R3]
    else $error("own reset pulse reported as request");
  rst_busy_a: assert property (o_master_rst_pin_oe |-> cfg_reg[mcp_pkg::CFG_RST_PULSE_BIT]) // [R2]
    else $error("pulse bit reads low while pulse runs");
  pulse_done_a: assert property ($fell(o_master_rst_pin_oe) |-> sts_reg[mcp_pkg::STS_PULSE_DONE_BIT]) // [R2]
    else $error("pulse end not flagged in status");
  ext_event_a: assert property (ext_low_s |=> sts_reg[mcp_pkg::STS_EXT_RST_BIT]) // [R3]
    else $error("external reset event not flagged");

  // Test pins and status bits
  aout_follow_a: assert property (!test_sync |=> o_analog_out_en) // [R5]
    else $error("analog output not enabled outside test mode");
  result_off_a: assert property (!test_sync |=> !o_test_result_or_addr_select_oe) // [R4]
    else $error("address pin driven outside test mode");
  vid_irq_hi_a: assert property (vid_mode_reg[4] && vid_prev_reg[4] && !vid_sync[4] |=> sts_reg[4]) // [R8]
    else $error("fifth voltage-ID interrupt event lost");
  sticky_bits_a: assert property (!(wr_fire && hit_clr) |=> (sts_reg & $past(sts_reg)) == $past(sts_reg)) // [R8]
    else $error("status bit lost without a clear");
  irq_level_a: assert property (irq_any |=> o_irq) // [R8]
    else $error("pending enabled event without interrupt");

endmodule // mcp_top

// >>> rtl/mcp_pkg.sv
// Shared constants and types for the monitor control-pin block
package mcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB window
  localparam logic [7:0] CFG_OFS       = 8'h40;
  localparam logic [7:0] VID_LO_OFS    = 8'h50;
  localparam logic [7:0] VID_HI_OFS    = 8'h54;
  localparam logic [7:0] VID_MODE_OFS  = 8'h58;
  localparam logic [7:0] IRQ_STS_OFS   = 8'h60;
  localparam logic [7:0] IRQ_CLR_OFS   = 8'h64;
  localparam logic [7:0] IRQ_EN_OFS    = 8'h68;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_INT_EN_BIT   = 1;
  localparam int CFG_RST_PULSE_BIT = 4;
  localparam int STS_EXT_RST_BIT  = 5;
  localparam int STS_PULSE_DONE_BIT = 6;
  localparam int VID_W            = 5;
  localparam int STS_W            = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]       CFG_RST      = 8'h00;
  localparam logic [VID_W-1:0] VID_MODE_RST = 5'h00;
  localparam logic [STS_W-1:0] IRQ_EN_RST   = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint unsigned CLK_HZ        = 64'd40000000;
  localparam longint unsigned RST_PULSE_MS  = 64'd45;
  localparam longint unsigned RST_PULSE_CYC = (RST_PULSE_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam int              RST_GUARD_CYC = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mcp_apb_req_t;

  typedef enum logic [1:0] {
    RST_IDLE  = 2'b00,
    RST_DRIVE = 2'b01,
    RST_GUARD = 2'b11
  } mcp_rst_state_t;

endpackage

// >>> rtl/mcp_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module mcp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Level in and out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= INIT;
      o_q      <= INIT;
    end else begin
      meta_reg <= i_d;                    // [R9]
      o_q      <= meta_reg;
    end
  end

  sync_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R9]
    $past(i_rst_n, 2) |-> o_q == $past(i_d, 2))
    else $error("synchroniser output is not the input two cycles late");

endmodule // mcp_sync

// >>> rtl/mcp_pulse_timer.sv
// Down-counter that times the minimum reset pulse
`timescale 1ns/1ps
module mcp_pulse_timer #(
  parameter int unsigned CYC = 1800000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_start,
  output logic      o_done
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_reg;
  logic          run_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= run_reg && cnt_reg == CW'(1);
      if (i_start) begin
        cnt_reg <= CW'(CYC);
        run_reg <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - CW'(1);
        run_reg <= cnt_reg != CW'(1);
      end
    end
  end

  done_spacing_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
    i_start |-> !o_done [*2])
    else $error("pulse timer finished too soon after start");

endmodule // mcp_pulse_timer

// >>> dv/mcp_board.sv
// Board-side model of the reset, interrupt and address-strap wiring
`timescale 1ns/1ps
module mcp_board (
  // Pin drivers on the board and in the device
  input  wire logic i_rst_oe,
  input  wire logic i_ext_pull,
  input  wire logic i_int_oe,
  input  wire logic i_res_o,
  input  wire logic i_res_oe,
  input  wire logic i_addr_strap,
  // Resolved wire levels
  output logic      o_rst_level,
  output logic      o_int_level,
  output logic      o_addr_level
);
  // Open-drain reset wire with pull-up, low when either side pulls it
  assign o_rst_level  = !(i_rst_oe || i_ext_pull);
  // Open-drain interrupt wire with pull-up
  assign o_int_level  = !i_int_oe;
  // Strap level unless the device drives the test result
  assign o_addr_level = i_res_oe ? i_res_o : i_addr_strap;
endmodule // mcp_board

// >>> dv/test_mcp_top.sv
// Self-checking bench for the monitor control-pin block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module test_mcp_top;
  localparam int P = 20;
  logic        clk = 0, rst_n = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, irq, int_o, int_oe, mrst_o, mrst_oe, reset_req;
  logic        test_sel = 0, aout_en, test_mode, res_o, res_oe;
  logic [4:0]  vid = 5'h1f;
  logic        ext_pull = 0, strap = 1, rst_level, int_level, addr_level;
  logic [32:0] exp_q[$];
  string       name_q[$];
  string       cur_nm;
  logic [32:0] cur_exp;
  int          failures = 0, checked = 0, n;
  logic [4:0]  r;

  always #12.5 clk = ~clk;

  mcp_top #(.RST_PULSE_CYC(P)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .o_int_pin_o(int_o), .o_int_pin_oe(int_oe), .i_master_rst_pin(rst_level),
    .o_master_rst_pin_o(mrst_o), .o_master_rst_pin_oe(mrst_oe), .o_reset_req(reset_req),
    .i_test_select_or_analog_out(test_sel), .o_analog_out_en(aout_en), .o_test_mode(test_mode),
    .o_test_result_or_addr_select_o(res_o), .o_test_result_or_addr_select_oe(res_oe),
    .i_core_volt_id_0(vid[0]), .i_core_volt_id_1(vid[1]), .i_core_volt_id_2(vid[2]),
    .i_core_volt_id_3(vid[3]), .i_core_volt_id_4(vid[4]));

  mcp_board board (
    .i_rst_oe(mrst_oe), .i_ext_pull(ext_pull), .i_int_oe(int_oe), .i_res_o(res_o),
    .i_res_oe(res_oe), .i_addr_strap(strap), .o_rst_level(rst_level), .o_int_level(int_level),
    .o_addr_level(addr_level));

  ////////////////////////////////////////////////////////////////////////////
  // Read monitor: each completed read is matched to the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("MISMATCH read_queue exp=note got=none");
      end else begin
        cur_nm  = name_q.pop_front();
        cur_exp = exp_q.pop_front();
        `CHK(cur_nm, cur_exp, {pslverr, prdata})
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB master: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input string nm);
    if (!w) begin
      exp_q.push_back(e);
      name_q.push_back(nm);
    end
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0, "");
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input string nm);
    apb(1'b0, a, '0, e, nm);
  endtask

  // Let pin changes pass the synchroniser and output flop; outputs are read as sampled at the last edge
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic done(input string nm);
    @(posedge clk);
    $display("test %s done", nm);
  endtask

  task automatic give_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(25.0 * 6000);
    failures++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    void'($urandom(81866));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset state and register defaults
    #1;
    `CHK("int_level", 1'b1, int_level)
    `CHK("aout_en", 1'b1, aout_en)
    `CHK("rst_oe", 1'b0, mrst_oe)
    `CHK("int_drv", 1'b0, int_o)
    `CHK("rst_drv", 1'b0, mrst_o)
    @(posedge clk);
    rd(mcp_pkg::CFG_OFS, 33'h0, "cfg_rst");
    rd(mcp_pkg::VID_MODE_OFS, 33'h0, "mode_rst");
    rd(8'h7c, {1'b1, 32'h0}, "unmapped");
    done("reset");
    // Random VID levels into the two status registers
    for (int i = 0; i < 4; i++) begin
      r = 5'($urandom());
      vid <= r;
      settle(4);
      rd(mcp_pkg::VID_LO_OFS, {29'h0, r[3:0]}, "vid_lo");
      rd(mcp_pkg::VID_HI_OFS, {32'h0, r[4]}, "vid_hi");
    end
    vid <= 5'h1f;
    settle(4);
    done("vid");
    // VID pins as interrupt inputs, interrupt pin gating and masking
    wr(mcp_pkg::VID_MODE_OFS, 32'h1f);
    wr(mcp_pkg::IRQ_EN_OFS, 32'h7f);
    vid <= 5'h00;
    settle(4);
    rd(mcp_pkg::IRQ_STS_OFS, 33'h1f, "sts_vid");
    rd(mcp_pkg::VID_LO_OFS, 33'h0, "vid_lo_irq");
    `CHK("irq", 1'b1, irq)
    `CHK("int_off", 1'b1, int_level)
    wr(mcp_pkg::CFG_OFS, 32'h02);
    settle(3);
    `CHK("int_on", 1'b0, int_level)
    wr(mcp_pkg::IRQ_EN_OFS, 32'h00);
    settle(2);
    `CHK("irq_masked", 1'b0, irq)
    wr(mcp_pkg::IRQ_CLR_OFS, 32'h1f);
    rd(mcp_pkg::IRQ_STS_OFS, 33'h0, "sts_clr");
    rd(mcp_pkg::IRQ_CLR_OFS, 33'h0, "clr_read");
    vid <= 5'h1f;
    settle(4);
    done("irq");
    // Software reset pulse: width and no self-reported request
    wr(mcp_pkg::CFG_OFS, 32'h12);
    n = 0;
    for (int k = 0; k < 4 * P && (n == 0 || mrst_oe); k++) begin
      settle(1);
      if (mrst_oe) n++;
      `CHK("own_req", 1'b0, reset_req)
    end
    `CHK("pulse_ok", 1'b1, n >= P)
    settle(5);
    rd(mcp_pkg::IRQ_STS_OFS, 33'h40, "sts_pulse");
    rd(mcp_pkg::CFG_OFS, 33'h02, "cfg_selfclr");
    done("pulse");
    // Outside source pulls the reset wire low
    ext_pull <= 1'b1;
    settle(4);
    `CHK("ext_req", 1'b1, reset_req)
    ext_pull <= 1'b0;
    settle(4);
    `CHK("ext_rel", 1'b0, reset_req)
    rd(mcp_pkg::IRQ_STS_OFS, 33'h60, "sts_ext");
    done("extreset");
    // Connectivity test mode and return to analog output
    test_sel <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 5'h1f : 5'($urandom());
      vid <= r;
      settle(4);
      `CHK("test_mode", 1'b1, test_mode)
      `CHK("aout_off", 1'b0, aout_en)
      `CHK("result", ~&r, addr_level)
    end
    test_sel <= 1'b0;
    strap    <= 1'b0;
    settle(4);
    `CHK("aout_back", 1'b1, aout_en)
    `CHK("strap", 1'b0, addr_level)
    done("testmode");
    give_verdict();
  end
endmodule // test_mcp_top
